/* File: hdl/tx_length_cfg.svh */
// Register offsets, field positions and reset values of the transmit length registers
`ifndef TX_LENGTH_CFG_SVH
`define TX_LENGTH_CFG_SVH

`define TXLEN_UPPER_ADDR      5'h1D
`define TXLEN_LOWER_ADDR      5'h1E
`define TXLEN_RESET_VALUE     8'h00
`define TXLEN_FLAG_BIT        0
`define TXLEN_PBITS_LSB       1
`define TXLEN_PBITS_MSB       3
`define TXLEN_LOWCNT_LSB      4
`define TXLEN_LOWCNT_MSB      7
`define TXLEN_HIGHCNT_LSB     4
`define TXLEN_HIGHCNT_MSB     7
`define TXLEN_MIDCNT_LSB      0
`define TXLEN_MIDCNT_MSB      3

`endif

/* File: hdl/tx_length_pkg.sv */
// Types shared by the transmit length register bank
package tx_length_pkg;
	typedef logic [11:0] byte_count_t;
	typedef logic [2:0]  partial_bits_t;
endpackage : tx_length_pkg

/* File: hdl/tx_frame_length_registers.sv */
// Transmit frame length register pair: complete byte count and partial last byte
// Notes on behaviour
// (R1) Upper register holds count bits 11..8 in bits 7..4, bits 7..4 in bits 3..0.
// (R2) Lower register bits 7..4 hold count bits 3..0, completing the 12-bit count.
// (R3) Lower register bits 3..1 give the number of bits sent from the partial byte.
// (R4) Partial bit count is ignored unless the partial-byte flag is set.
// (R5) Lower register bit 0 set marks the final byte as narrower than eight bits.
// (R6) Both registers are zero after reset and while chip enable is low.
// (R7) Both registers clear by themselves at transmit end of frame.
// (R8) Host writes both registers before loading data, again for every frame.
`include "tx_length_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module tx_frame_length_registers (
	input  wire logic                         clk,
	input  wire logic                         reset,
	input  wire logic                         chipEnable,
	input  wire logic                         regWrite,
	input  wire logic [4:0]                   regAddr,
	input  wire logic [7:0]                   regWriteData,
	input  wire logic                         txEndOfFrame,
	output logic      [7:0]                   regReadData,
	output logic      [7:0]                   txLengthUpper,
	output logic      [7:0]                   txLengthLowerPartial,
	output tx_length_pkg::byte_count_t        byteCount,
	output tx_length_pkg::partial_bits_t      lastByteBits,
	output logic                              lastBytePartial
);

	// Register state and its next values
	logic [7:0]                   upper_r;
	logic [7:0]                   lower_r;
	logic [7:0]                   upper_nxt;
	logic [7:0]                   lower_nxt;

	// Chip enable synchroniser stages
	logic                         enSync1_r;
	logic                         enSync2_r;

	// Decoded address matches and write strobes
	logic                         upperHit;
	logic                         lowerHit;
	logic                         upperWrite;
	logic                         lowerWrite;
	logic                         holdClear;

	// Named fields of the two registers
	logic [3:0]                   countHighNibble;
	logic [3:0]                   countMidNibble;
	logic [3:0]                   countLowNibble;
	tx_length_pkg::partial_bits_t partialBitsField;
	logic                         lowerPartialFlag;

	// Next values of the registered outputs
	logic [7:0]                   readData_nxt;
	tx_length_pkg::byte_count_t   byteCount_nxt;
	tx_length_pkg::partial_bits_t lastByteBits_nxt;

	// Chip enable arrives from a pin
	always_ff @(posedge clk) begin
		if (reset) begin
			enSync1_r <= 1'b0;
			enSync2_r <= 1'b0;
		end else begin
			enSync1_r <= chipEnable;
			enSync2_r <= enSync1_r;
		end
	end

	// Address match for each register
	always_comb begin
		upperHit = (regAddr == `TXLEN_UPPER_ADDR);
		lowerHit = (regAddr == `TXLEN_LOWER_ADDR);
	end

	// Writes count only with the strobe high
	always_comb begin
		upperWrite = regWrite && upperHit;
		lowerWrite = regWrite && lowerHit;
	end

	// (R6) clear on reset or disable
	always_comb begin
		holdClear = reset || !enSync2_r;
	end

	// (R7) end of frame beats write
	always_comb begin
		upper_nxt = upper_r;
		if (txEndOfFrame) begin
			upper_nxt = `TXLEN_RESET_VALUE;
		end else if (upperWrite) begin
			upper_nxt = regWriteData;
		end
	end

	// (R7) end of frame beats write
	always_comb begin
		lower_nxt = lower_r;
		if (txEndOfFrame) begin
			lower_nxt = `TXLEN_RESET_VALUE;
		end else if (lowerWrite) begin
			lower_nxt = regWriteData;
		end
	end

	// (R6) upper register zero when held
	always_ff @(posedge clk) begin
		if (holdClear) begin
			upper_r <= `TXLEN_RESET_VALUE;
		end else begin
			upper_r <= upper_nxt;
		end
	end

	// (R6) lower register zero when held
	always_ff @(posedge clk) begin
		if (holdClear) begin
			lower_r <= `TXLEN_RESET_VALUE;
		end else begin
			lower_r <= lower_nxt;
		end
	end

	// (R1) high and middle nibbles
	always_comb begin
		countHighNibble = upper_r[`TXLEN_HIGHCNT_MSB:`TXLEN_HIGHCNT_LSB];
		countMidNibble  = upper_r[`TXLEN_MIDCNT_MSB:`TXLEN_MIDCNT_LSB];
	end

	// (R2) low count nibble
	always_comb begin
		countLowNibble = lower_r[`TXLEN_LOWCNT_MSB:`TXLEN_LOWCNT_LSB];
	end

	// (R3) partial bit count field
	always_comb begin
		partialBitsField = lower_r[`TXLEN_PBITS_MSB:`TXLEN_PBITS_LSB];
	end

	// (R5) partial-byte flag
	always_comb begin
		lowerPartialFlag = lower_r[`TXLEN_FLAG_BIT];
	end

	// (R1) (R2) assemble count
	always_comb begin
		byteCount_nxt = {countHighNibble, countMidNibble, countLowNibble};
	end

	// (R4) bits used only with flag
	always_comb begin
		lastByteBits_nxt = 3'h0;
		if (lowerPartialFlag) begin
			lastByteBits_nxt = partialBitsField;
		end
	end

	// Read mux, zero for other addresses
	always_comb begin
		readData_nxt = 8'h00;
		if (upperHit) begin
			readData_nxt = upper_r;
		end else if (lowerHit) begin
			readData_nxt = lower_r;
		end
	end

	// Read data one cycle after the address
	always_ff @(posedge clk) begin
		if (reset) begin
			regReadData <= 8'h00;
		end else begin
			regReadData <= readData_nxt;
		end
	end

	// Copy of the upper register
	always_ff @(posedge clk) begin
		if (reset) begin
			txLengthUpper <= 8'h00;
		end else begin
			txLengthUpper <= upper_r;
		end
	end

	// Copy of the lower register
	always_ff @(posedge clk) begin
		if (reset) begin
			txLengthLowerPartial <= 8'h00;
		end else begin
			txLengthLowerPartial <= lower_r;
		end
	end

	// (R1) (R2) complete byte count
	always_ff @(posedge clk) begin
		if (reset) begin
			byteCount <= 12'h000;
		end else begin
			byteCount <= byteCount_nxt;
		end
	end

	// (R3) (R4) partial bit count
	always_ff @(posedge clk) begin
		if (reset) begin
			lastByteBits <= 3'h0;
		end else begin
			lastByteBits <= lastByteBits_nxt;
		end
	end

	// (R5) last byte partial
	always_ff @(posedge clk) begin
		if (reset) begin
			lastBytePartial <= 1'b0;
		end else begin
			lastBytePartial <= lowerPartialFlag;
		end
	end

endmodule : tx_frame_length_registers

`default_nettype wire

/* File: verif/tx_len_chk_sva.sv */
// Port assertions for the length registers
`timescale 1ns/1ns
`default_nettype none
module tx_len_chk (input wire logic clk, reset, chipEnable, txEndOfFrame, lastBytePartial,
	input wire logic [7:0] regReadData, txLengthUpper, txLengthLowerPartial,
	input wire logic [11:0] byteCount, input wire logic [2:0] lastByteBits);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_cnt; byteCount == {txLengthUpper, txLengthLowerPartial[7:4]}; endproperty
	a_cnt: assert property (p_cnt) else $error("count");
	property p_bb; lastByteBits == (txLengthLowerPartial[0] ? txLengthLowerPartial[3:1] : 3'h0); endproperty
	a_bb: assert property (p_bb) else $error("bits");
	property p_eof; txEndOfFrame |-> ##2 {txLengthUpper, txLengthLowerPartial} == 16'h0000; endproperty
	a_eof: assert property (p_eof) else $error("eof");
	property p_en; !chipEnable[*5] |-> {txLengthUpper, txLengthLowerPartial, regReadData} == 24'h000000; endproperty
	a_en: assert property (p_en) else $error("enable");
	property p_hi; byteCount[11:4] == txLengthUpper; endproperty
	a_hi: assert property (p_hi) else $error("upper");
	property p_pf; lastBytePartial == txLengthLowerPartial[0]; endproperty
	a_pf: assert property (p_pf) else $error("flag");
	property p_pb; lastBytePartial |-> lastByteBits == txLengthLowerPartial[3:1]; endproperty
	a_pb: assert property (p_pb) else $error("partial bits");
endmodule : tx_len_chk
bind tx_frame_length_registers tx_len_chk chk_u (.*);
`default_nettype wire

/* File: verif/host_model.sv */
// Host writing and reading the length registers
`timescale 1ns/1ns
`default_nettype none
module host_model (input wire logic clk, input wire logic [7:0] q, output logic w, output logic [4:0] a, output logic [7:0] d);
	initial {w, a, d} = 14'h0000;
	task wr(input logic [4:0] x, input logic [7:0] y);
		@(negedge clk) {w, a, d} = {1'h1, x, y};
		@(negedge clk) w = 1'h0;
	endtask : wr
	task rd(input logic [4:0] x, output logic [7:0] y);
		@(negedge clk) a = x;
		@(negedge clk) y = q;
	endtask : rd
endmodule : host_model
`default_nettype wire

/* File: verif/test_tx_frame_length_registers.sv */
// Bench for the length registers
`timescale 1ns/1ns
`default_nettype none
module test_tx_frame_length_registers;
	logic clk = 1'h0, reset = 1'h1, en = 1'h1, eof = 1'h0, w, pf;
	logic [4:0] a; logic [7:0] d, q, up, lo, r; logic [11:0] n; logic [2:0] bb;
	int fail_count = 0, n_compared = 0;
	always #5 clk = ~clk;
	host_model host_u (.clk(clk), .q(q), .w(w), .a(a), .d(d));
	tx_frame_length_registers dut_u (.clk(clk), .reset(reset), .chipEnable(en), .regWrite(w), .regAddr(a),
		.regWriteData(d), .txEndOfFrame(eof), .regReadData(q), .txLengthUpper(up), .txLengthLowerPartial(lo),
		.byteCount(n), .lastByteBits(bb), .lastBytePartial(pf));
	task c(input logic [15:0] g, e);
		n_compared++;
		if (g !== e) begin fail_count++; $display("Error %0t %h %h", $time, g, e); end
	endtask : c
	task report_and_stop;
		$display("%0d compared %0d failed", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	initial begin #3000; fail_count++; report_and_stop; end
	initial begin
		repeat (4) @(negedge clk); reset = 1'h0;
		host_u.rd(5'h1E, r); c(r, 8'h00);
		host_u.wr(5'h1D, 8'hA5); host_u.wr(5'h1E, 8'h3B);
		host_u.rd(5'h1D, r); c(r, 8'hA5); c(n, 12'hA53); c(bb, 3'h5); c(pf, 1'h1);
		host_u.rd(5'h1E, r); c(r, 8'h3B); c(lo, 8'h3B);
		host_u.wr(5'h1E, 8'h3E); host_u.rd(5'h1C, r); c(r, 8'h00); c(bb, 3'h0); c(pf, 1'h0);
		$display("count test done");
		@(negedge clk) eof = 1'h1; @(negedge clk) eof = 1'h0; @(negedge clk); c({up, lo}, 16'h0000);
		host_u.wr(5'h1D, 8'h5C); @(negedge clk); c(up, 8'h5C);
		en = 1'h0; host_u.wr(5'h1D, 8'hFF); repeat (4) @(negedge clk); c(up, 8'h00);
		$display("clear test done");
		report_and_stop;
	end
endmodule : test_tx_frame_length_registers
`default_nettype wire
